// file: rtl/bde_branch_unit.sv
// branch decode and execute unit with wishbone control registers
//
// Contract
// - negative-literal branch: pc plus extended literal if source below zero, else pc plus four.
// - nonzero-register branch: taken gives pc plus offset register, else pc plus four.
// - not-equal forms taken exactly when source differs from zero; literal form adds literal.
// - delayed taken branch lets the next instruction complete before target.
// - undelayed taken branch goes straight to target, squashing the sequential instruction.
// - literal conditional branch takes one cycle if untaken or correctly predicted.
// - taken conditional branch with delay takes two cycles.
// - taken undelayed branch, or misprediction at area setting zero, takes three cycles.
// - misprediction at area setting two costs seven to nine cycles.
// - register not-equal branch takes one cycle untaken; no prediction shortening.
// - sixteen-bit literal is sign-extended to thirty-two bits by default.
// - prefix op right before a literal branch supplies the upper literal half.
// - linking register branch writes its own pc into the link register.
// - absolute flag makes the offset register the new pc.
// - clear absolute flag branches to pc plus the offset register.
// - absolute, link and delay flags are set per the register branch forms.
// - unconditional register branches take two cycles delayed, three undelayed.
// - interrupts and breaks held off until the delay-slot instruction completes.
// - linking register branches exist only delayed; undelayed link encodings unsupported.
// - in 64-bit mode absolute branches and link use full 64-bit values.
// - register branch: link field at bit 6, flags from 11, offset at 16.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module bde_branch_unit (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// issue from decode
	input wire logic issue_valid_in,
	input wire bde_pkg::bde_issue_t issue_in,
	output logic issue_ready_out,
	// program counter redirect
	output logic pc_load_out,
	output logic [63:0] pc_target_out,
	output logic flush_out,
	// register file link write
	output logic link_we_out,
	output logic [4:0] link_addr_out,
	output logic [63:0] link_data_out,
	// interrupt and break deferral, bad encoding
	output logic irq_hold_out,
	output logic illegal_out,
	// wishbone classic slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out
);

	`include "bde_regs.svh"

	// ==========================================================
	// state
	bde_pkg::bde_state_t st_ff;
	bde_pkg::bde_state_t nxt_st;

	// ==========================================================
	// decode of the issued word
	logic [31:0] ins;
	logic [5:0] opcode;
	logic [3:0] cc;
	logic accept;
	logic dly;
	logic abs_f;
	logic lnk_f;
	logic neg;
	logic nonzero;
	logic cond_true;
	logic taken;
	logic mispredict;
	logic good_guess;
	logic [63:0] lit_ext;
	logic [63:0] raw_target;
	logic [63:0] fit_target;
	logic [3:0] lat;
	bde_pkg::bde_kind_t kind;

	assign ins = issue_in.instr;
	assign opcode = ins[`BDE_F_OP_MSB:`BDE_F_OP_LSB];
	assign cc = ins[`BDE_F_CC_MSB:`BDE_F_CC_LSB];
	assign accept = issue_valid_in & st_ff.ready;

	// classify; only the branch forms this unit owns are recognised
	always_comb begin
		kind = bde_pkg::BDE_K_NONE;
		if (opcode == `BDE_OP_COND_REG && cc == `BDE_CC_NE) begin
			kind = bde_pkg::BDE_K_NE_REG;
		end else if (opcode == `BDE_OP_COND_LIT && (cc == `BDE_CC_NE || cc == `BDE_CC_LT)) begin
			kind = bde_pkg::BDE_K_LIT;
		end else if (opcode == `BDE_OP_JREG) begin
			// link without delay has no defined meaning
			if (ins[`BDE_F_LNK] && !ins[`BDE_F_DLY_JREG]) begin
				kind = bde_pkg::BDE_K_BAD_LINK;
			end else begin
				kind = bde_pkg::BDE_K_JREG;
			end
		end
	end

	// flag extraction, positions differ between the two encodings
	assign dly = (opcode == `BDE_OP_JREG) ? ins[`BDE_F_DLY_JREG] : ins[`BDE_F_DLY_COND];
	assign abs_f = ins[`BDE_F_ABS];
	assign lnk_f = ins[`BDE_F_LNK];

	// signed view of the source at the native width
	assign neg = st_ff.mode64 ? issue_in.opa[63] : issue_in.opa[31];
	assign nonzero = st_ff.mode64 ? (|issue_in.opa) : (|issue_in.opa[31:0]);

	// less-than-zero or not-equal
	assign cond_true = (cc == `BDE_CC_LT) ? neg : nonzero;

	always_comb begin
		taken = 1'b0;
		unique case (kind)
			bde_pkg::BDE_K_NE_REG: taken = cond_true;
			bde_pkg::BDE_K_LIT: taken = cond_true;
			bde_pkg::BDE_K_JREG: taken = 1'b1;
			bde_pkg::BDE_K_BAD_LINK: taken = 1'b0;
			bde_pkg::BDE_K_NONE: taken = 1'b0;
		endcase
	end

	// literal: sign-extend 16 bits, or join the held prefix half
	always_comb begin
		if (st_ff.pfx_valid) begin
			lit_ext = {{32{st_ff.pfx_hi[15]}}, st_ff.pfx_hi, ins[`BDE_F_LIT_MSB:0]};
		end else begin
			lit_ext = {{48{ins[`BDE_F_LIT_MSB]}}, ins[`BDE_F_LIT_MSB:0]};
		end
	end

	// target selection
	always_comb begin
		raw_target = issue_in.pc + 64'h0000000000000004; // untaken
		if (taken) begin
			if (kind == bde_pkg::BDE_K_LIT) begin
				raw_target = issue_in.pc + lit_ext;
			end else if (kind == bde_pkg::BDE_K_JREG && abs_f) begin
				raw_target = issue_in.opb;
			end else begin
				raw_target = issue_in.pc + issue_in.opb;
			end
		end
	end

	// 32-bit mode keeps only the low word; 64-bit keeps all of it
	assign fit_target = st_ff.mode64 ? raw_target : {32'h00000000, raw_target[31:0]};

	// prediction only counts for literal forms; register forms ignore it
	assign mispredict = (kind == bde_pkg::BDE_K_LIT) & issue_in.pred_valid
		& (issue_in.pred_taken != taken);

	// fetch already followed a right guess on a literal form
	assign good_guess = (kind == bde_pkg::BDE_K_LIT) & issue_in.pred_valid & !mispredict;

	// latency in cycles for the accepted instruction
	always_comb begin
		lat = `BDE_LAT_SHORT; // untaken, prefix, other
		if (kind == bde_pkg::BDE_K_LIT && issue_in.pred_valid && !mispredict) begin
			lat = `BDE_LAT_SHORT; // correct prediction
		end else if (mispredict) begin
			// the fast configuration pays a longer refill
			lat = (st_ff.area == `BDE_AREA_FAST) ? `BDE_LAT_MISS_A2 : `BDE_LAT_FULL;
		end else if (taken && dly) begin
			lat = `BDE_LAT_DELAYED;
		end else if (taken) begin
			lat = `BDE_LAT_FULL;
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pc_load = 1'b0;
		nxt_st.link_we = 1'b0;
		nxt_st.flush = 1'b0;
		nxt_st.illegal = 1'b0;
		nxt_st.ack = 1'b0;

		// stall countdown; ready returns when it runs out
		if (st_ff.cnt != 4'h0) begin
			nxt_st.cnt = st_ff.cnt - 4'h1;
		end

		if (accept) begin
			nxt_st.cnt = lat - 4'h1;
			// the delay-slot instruction has now been issued
			nxt_st.irq_hold = 1'b0;
			// prefix lives for exactly the next instruction
			nxt_st.pfx_valid = (opcode == `BDE_OP_PREFIX);
			if (opcode == `BDE_OP_PREFIX) begin
				nxt_st.pfx_hi = ins[`BDE_F_LIT_MSB:0];
			end

			if (kind == bde_pkg::BDE_K_BAD_LINK) begin
				nxt_st.illegal = 1'b1;
			end

			// redirect when taken or mispredicted, unless the fetch side already followed a right guess
			if (kind != bde_pkg::BDE_K_NONE && kind != bde_pkg::BDE_K_BAD_LINK) begin
				nxt_st.target = fit_target;
				nxt_st.pc_load = taken | mispredict;
				if (kind == bde_pkg::BDE_K_LIT && issue_in.pred_valid && !mispredict) begin
					nxt_st.pc_load = 1'b0;
				end
			end

			if (taken) begin
				nxt_st.taken_cnt = st_ff.taken_cnt + 32'h00000001;
				// no slot: squash the sequential fetch
				// slot: keep it and hold off interrupts until it issues
				// relies on the slot never holding a branch or prefix
				// a right guess fetched the target already, squashing it would lose it
				if (dly) begin
					nxt_st.irq_hold = 1'b1;
				end else if (!good_guess) begin
					nxt_st.flush = 1'b1;
				end
			end else if (mispredict) begin
				nxt_st.flush = 1'b1;
			end

			// link gets the branch's own pc, full width in 64-bit mode
			if (kind == bde_pkg::BDE_K_JREG && lnk_f) begin
				nxt_st.link_we = 1'b1;
				nxt_st.link_addr = ins[`BDE_F_LINK_MSB:`BDE_F_LINK_LSB];
				nxt_st.link_data = st_ff.mode64 ? issue_in.pc
					: {32'h00000000, issue_in.pc[31:0]};
			end
		end
		nxt_st.ready = (nxt_st.cnt == 4'h0);

		// wishbone: answer one cycle after the strobe, drop ack after one cycle
		if (wb_cyc_in && wb_stb_in && !st_ff.ack) begin
			nxt_st.ack = 1'b1;
			nxt_st.rdat = 32'h00000000;
			unique case (wb_adr_in)
				`BDE_OFF_CTRL: begin
					nxt_st.rdat[`BDE_CTRL_MODE64_BIT] = st_ff.mode64;
					nxt_st.rdat[`BDE_CTRL_AREA_MSB:`BDE_CTRL_AREA_LSB] = st_ff.area;
				end
				`BDE_OFF_STATUS: begin
					nxt_st.rdat[`BDE_STAT_READY_BIT] = st_ff.ready;
					nxt_st.rdat[`BDE_STAT_IRQ_HOLD_BIT] = st_ff.irq_hold;
					nxt_st.rdat[`BDE_STAT_PFX_BIT] = st_ff.pfx_valid;
				end
				`BDE_OFF_TAKEN: nxt_st.rdat = st_ff.taken_cnt;
				default: nxt_st.rdat = 32'h00000000; // unmapped reads zero
			endcase
		end

		// writes land on the edge where the master sees ack
		if (wb_cyc_in && wb_stb_in && wb_we_in && st_ff.ack && wb_sel_in[0]) begin
			if (wb_adr_in == `BDE_OFF_CTRL) begin
				nxt_st.mode64 = wb_dat_in[`BDE_CTRL_MODE64_BIT];
				nxt_st.area = wb_dat_in[`BDE_CTRL_AREA_MSB:`BDE_CTRL_AREA_LSB];
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_ff <= '0;
			st_ff.ready <= 1'b1;
			st_ff.mode64 <= `BDE_RST_MODE64;
			st_ff.area <= `BDE_RST_AREA;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// outputs, all straight from the state register
	assign issue_ready_out = st_ff.ready;
	assign pc_load_out = st_ff.pc_load;
	assign pc_target_out = st_ff.target;
	assign flush_out = st_ff.flush;
	assign link_we_out = st_ff.link_we;
	assign link_addr_out = st_ff.link_addr;
	assign link_data_out = st_ff.link_data;
	assign irq_hold_out = st_ff.irq_hold;
	assign illegal_out = st_ff.illegal;
	assign wb_dat_out = st_ff.rdat;
	assign wb_ack_out = st_ff.ack;

endmodule

// file: rtl/bde_regs.svh
// constants for the branch decode and execute block
`ifndef BDE_REGS_SVH
`define BDE_REGS_SVH

// ==========================================================
// wishbone register map (byte addresses)
`define BDE_OFF_CTRL 8'h00
`define BDE_OFF_STATUS 8'h04
`define BDE_OFF_TAKEN 8'h08

// ctrl fields and reset values
`define BDE_CTRL_MODE64_BIT 0
`define BDE_CTRL_AREA_LSB 1
`define BDE_CTRL_AREA_MSB 2
`define BDE_RST_MODE64 1'h0
`define BDE_RST_AREA 2'h0

// status fields
`define BDE_STAT_READY_BIT 0
`define BDE_STAT_IRQ_HOLD_BIT 1
`define BDE_STAT_PFX_BIT 2

// ==========================================================
// opcodes (instruction bits 31:26) and condition codes (bits 24:21)
`define BDE_OP_COND_REG 6'h27
`define BDE_OP_COND_LIT 6'h2F
`define BDE_OP_JREG 6'h26
`define BDE_OP_PREFIX 6'h2C
`define BDE_CC_NE 4'h1
`define BDE_CC_LT 4'h2

// field positions, counted from the lsb of the instruction word
`define BDE_F_OP_MSB 31
`define BDE_F_OP_LSB 26
`define BDE_F_DLY_COND 25
`define BDE_F_CC_MSB 24
`define BDE_F_CC_LSB 21
`define BDE_F_LINK_MSB 25
`define BDE_F_LINK_LSB 21
`define BDE_F_DLY_JREG 20
`define BDE_F_ABS 19
`define BDE_F_LNK 18
`define BDE_F_LIT_MSB 15

// ==========================================================
// latencies in cycles
`define BDE_LAT_SHORT 4'h1
`define BDE_LAT_DELAYED 4'h2
`define BDE_LAT_FULL 4'h3
`define BDE_LAT_MISS_A2 4'h8
`define BDE_AREA_FAST 2'h2

`endif

// file: rtl/bde_pkg.sv
// types shared by the branch decode and execute block
package bde_pkg;

	// one issued instruction with its operands
	typedef struct packed {
		logic [31:0] instr;
		logic [63:0] pc;
		logic [63:0] opa;
		logic [63:0] opb;
		logic pred_valid;
		logic pred_taken;
	} bde_issue_t;

	// whole state of the branch unit
	typedef struct packed {
		logic [3:0] cnt;
		logic ready;
		logic pc_load;
		logic [63:0] target;
		logic link_we;
		logic [4:0] link_addr;
		logic [63:0] link_data;
		logic flush;
		logic irq_hold;
		logic illegal;
		logic pfx_valid;
		logic [15:0] pfx_hi;
		logic mode64;
		logic [1:0] area;
		logic [31:0] taken_cnt;
		logic ack;
		logic [31:0] rdat;
	} bde_state_t;

	// kinds of branch the decoder can see
	typedef enum logic [2:0] {
		BDE_K_NONE,
		BDE_K_NE_REG,
		BDE_K_LIT,
		BDE_K_JREG,
		BDE_K_BAD_LINK
	} bde_kind_t;

endpackage

// file: sim/bde_fetch_model.sv
// fetch and decode stage model feeding the branch unit
`timescale 1ns/1ps

module bde_fetch_model (
	// clock and handshake
	input wire logic clk_in,
	input wire logic ready_in,
	// offered instruction
	output logic valid_out,
	output bde_pkg::bde_issue_t issue_out
);
	// ==========
	// idle: nothing offered
	initial begin
		valid_out = 1'b0;
		issue_out = '0;
	end

	// offer one op and hold it until the edge that takes it
	task automatic send(input bde_pkg::bde_issue_t x);
		@(posedge clk_in);
		valid_out <= 1'b1;
		issue_out <= x;
		do @(posedge clk_in); while (ready_in !== 1'b1);
		valid_out <= 1'b0;
		issue_out <= ~x; // stale operands must never look like the last ones
	endtask
endmodule

// file: sim/bde_branch_unit_asserts.sv
// concurrent checks on the branch unit ports
`timescale 1ns/1ps

module bde_branch_unit_asserts (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic nrst_in,
	// issue side
	input wire logic issue_valid_in,
	input wire bde_pkg::bde_issue_t issue_in,
	input wire logic issue_ready_out,
	// results
	input wire logic pc_load_out,
	input wire logic [63:0] pc_target_out,
	input wire logic flush_out,
	input wire logic link_we_out,
	input wire logic [4:0] link_addr_out,
	input wire logic [63:0] link_data_out,
	input wire logic irq_hold_out,
	input wire logic illegal_out
);
	// ==========
	// decode of the taken op; upper operand half zero so both modes agree
	wire [31:0] ins = issue_in.instr;
	wire [4:0] rd = ins[25:21];
	wire [31:0] pc_lo = issue_in.pc[31:0];
	wire [31:0] ob_lo = issue_in.opb[31:0];
	wire [31:0] rel = pc_lo + ob_lo;
	wire acc = issue_valid_in && issue_ready_out;
	wire ne = acc && ins[24:21] == 4'h1 && issue_in.opa[63:32] == 32'h0;
	wire lit = ne && ins[31:26] == 6'h2F && !issue_in.pred_valid;
	wire nz = issue_in.opa[31:0] != 32'h0;
	wire jrf = acc && ins[31:26] == 6'h26;
	wire jr = jrf && !(ins[18] && !ins[20]);

	// ==========
	// properties
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	a_full_taken: assert property (lit && nz && !ins[25] |=>
		pc_load_out && flush_out && !issue_ready_out ##1 !issue_ready_out ##1 issue_ready_out)
		else $error("undelayed taken branch wrong");
	a_delay_slot: assert property (lit && nz && ins[25] |=>
		pc_load_out && !flush_out && irq_hold_out && !issue_ready_out ##1 issue_ready_out)
		else $error("delayed taken branch wrong");
	a_untaken_quiet: assert property ((lit || ne && ins[31:26] == 6'h27) && !nz |=>
		issue_ready_out && !pc_load_out)
		else $error("untaken branch not one cycle");
	a_right_guess: assert property (ne && ins[31:26] == 6'h2F && nz &&
		issue_in.pred_valid && issue_in.pred_taken |=>
		!pc_load_out && !flush_out && issue_ready_out)
		else $error("right guess not one cycle");
	a_hold_stays: assert property (irq_hold_out && !acc |=> irq_hold_out)
		else $error("hold dropped early");
	a_link_write: assert property (jr && ins[18] |=> link_we_out &&
		link_addr_out == $past(rd) && link_data_out[31:0] == $past(pc_lo))
		else $error("link write wrong");
	a_abs_target: assert property (jr && ins[19] |=>
		pc_load_out && pc_target_out[31:0] == $past(ob_lo))
		else $error("absolute target wrong");
	a_rel_target: assert property (jr && !ins[19] |=> pc_target_out[31:0] == $past(rel))
		else $error("relative target wrong");
	a_bad_link: assert property (jrf && ins[18] && !ins[20] |=>
		illegal_out && !pc_load_out && !link_we_out && issue_ready_out)
		else $error("undelayed link not refused");
	c_delayed: cover property (lit && nz && ins[25]);
	c_link: cover property (link_we_out);
	c_bad: cover property (illegal_out);
endmodule

bind bde_branch_unit bde_branch_unit_asserts u_bde_branch_unit_asserts (.core_clk_in, .nrst_in,
	.issue_valid_in, .issue_in, .issue_ready_out, .pc_load_out, .pc_target_out, .flush_out,
	.link_we_out, .link_addr_out, .link_data_out, .irq_hold_out, .illegal_out);

// file: sim/bde_branch_unit_bench.sv
// self-checking bench for the branch unit
`timescale 1ns/1ps

module bde_branch_unit_bench;
	// ==========
	// pins of the unit and bench state
	logic core_clk_in, nrst_in, issue_valid_in, issue_ready_out, pc_load_out, flush_out;
	logic link_we_out, irq_hold_out, illegal_out, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
	logic [7:0] wb_adr_in;
	logic [3:0] wb_sel_in;
	logic [31:0] wb_dat_in, wb_dat_out, q;
	logic [4:0] link_addr_out;
	logic [63:0] pc_target_out, link_data_out;
	bde_pkg::bde_issue_t issue_in;
	logic lw, il;
	logic [63:0] pc = 64'h100;
	int fails = 0;
	int n_checks = 0;
	localparam logic [63:0] z = 64'h0;

	// far side and unit
	bde_fetch_model u_bde_fetch_model (.clk_in(core_clk_in), .ready_in(issue_ready_out),
		.valid_out(issue_valid_in), .issue_out(issue_in));
	bde_branch_unit u_bde_branch_unit (.core_clk_in, .nrst_in, .issue_valid_in, .issue_in,
		.issue_ready_out, .pc_load_out, .pc_target_out, .flush_out, .link_we_out,
		.link_addr_out, .link_data_out, .irq_hold_out, .illegal_out, .wb_cyc_in, .wb_stb_in,
		.wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out);

	// 125 MHz clock
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	// ==========
	// compare, verdict and bus tasks
	task automatic chk(input string nm, input logic [63:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge core_clk_in);
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'h3, w, ad, d};
		do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
		q = wb_dat_out;
		{wb_cyc_in, wb_stb_in} <= 2'h0;
	endtask

	// fl holds pred_valid, pred_taken, expected load, expected flush
	task automatic br(input logic [31:0] ins, input logic [63:0] a, b,
		input logic [3:0] fl, input logic [63:0] et, input logic [3:0] ln);
		logic [3:0] n;
		n = 4'h1;
		u_bde_fetch_model.send('{ins, pc, a, b, fl[3], fl[2]});
		#1;
		lw = link_we_out;
		il = illegal_out;
		chk("pc load", pc_load_out, fl[1]);
		chk("flush", flush_out, fl[0]);
		if (fl[1]) begin
			chk("target", pc_target_out, et);
		end
		// latency: cycles until ready comes back
		while (issue_ready_out !== 1'b1 && n < 4'hF) begin
			@(posedge core_clk_in);
			#1;
			n++;
		end
		chk("latency", n, ln);
	endtask

	// a plain op, the only kind placed in a delay slot
	task automatic slot;
		br(32'h0, z, z, 4'h0, z, 4'h1);
	endtask

	function automatic logic [31:0] lit(input logic [3:0] cc, input logic d, input logic [15:0] im);
		return {6'h2F, d, cc, 5'h0, im};
	endfunction

	function automatic logic [31:0] jr(input logic [4:0] rd, input logic d, a, l);
		return {6'h26, rd, d, a, l, 7'h0, 11'h0};
	endfunction

	function automatic logic [31:0] ner(input logic d);
		return {6'h27, d, 4'h1, 21'h0};
	endfunction

	// ==========
	// test sequence
	initial begin
		nrst_in = 1'b0;
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} = '0;
		wb_sel_in = 4'hF;
		repeat (20) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		wb(1'b0, 8'h00, 32'h0);
		chk("ctrl", q, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", q, 32'h0);
		br(lit(4'h2, 1'b0, 16'hFFF0), 64'h8000_0000, z, 4'h3, 64'hF0, 4'h3);
		br(lit(4'h2, 1'b0, 16'h0010), z, z, 4'h0, z, 4'h1);
		br(lit(4'h1, 1'b1, 16'h0020), 64'h5, z, 4'h2, 64'h120, 4'h2);
		chk("hold", irq_hold_out, 1'b1);
		slot();
		chk("hold", irq_hold_out, 1'b0);
		br(lit(4'h1, 1'b0, 16'h0020), 64'h1, z, 4'hC, z, 4'h1);
		br(lit(4'h1, 1'b0, 16'h0020), z, z, 4'hF, 64'h104, 4'h3);
		wb(1'b1, 8'h00, 32'h4);
		br(lit(4'h1, 1'b0, 16'h0020), 64'h1, z, 4'hB, 64'h120, 4'h8);
		wb(1'b1, 8'h00, 32'h0);
		br(ner(1'b0), 64'h1, 64'h40, 4'hF, 64'h140, 4'h3);
		br(ner(1'b0), z, 64'h40, 4'h0, z, 4'h1);
		br(jr(5'h0, 1'b1, 1'b0, 1'b0), z, 64'h30, 4'h2, 64'h130, 4'h2);
		slot();
		br(jr(5'h0, 1'b0, 1'b1, 1'b0), z, 64'h800, 4'h3, 64'h800, 4'h3);
		br(jr(5'h5, 1'b1, 1'b1, 1'b1), z, 64'h800, 4'h2, 64'h800, 4'h2);
		chk("link we", lw, 1'b1);
		chk("link addr", link_addr_out, 5'h5);
		chk("link data", link_data_out, pc);
		slot();
		br(jr(5'h5, 1'b0, 1'b0, 1'b1), z, 64'h800, 4'h0, z, 4'h1);
		chk("illegal", il, 1'b1);
		br({6'h2C, 10'h0, 16'h1234}, z, z, 4'h0, z, 4'h1);
		br(lit(4'h1, 1'b0, 16'h0010), 64'h1, z, 4'h3, 64'h1234_0110, 4'h3);
		wb(1'b1, 8'h00, 32'h1);
		pc = 64'hA_0000_0000;
		br(jr(5'h7, 1'b1, 1'b1, 1'b1), z, 64'h1_2345_6780, 4'h2, 64'h1_2345_6780, 4'h2);
		chk("link64", link_data_out, 64'hA_0000_0000);
		slot();
		final_report;
	end

	// hang guard, far beyond the hundred or so cycles the tests need
	initial begin
		repeat (3000) @(posedge core_clk_in);
		fails++;
		final_report;
	end
endmodule
